//--- hdl/dpt_regs.svh
// Register indices, field positions, reset values and timing counts of the pulse train block
// Assumes a 40 MHz hclk and an AHB-Lite slave with byte address = 4 * word index
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH

`define DPT_IDX_RANGE       5'h00
`define DPT_IDX_FREQ        5'h01
`define DPT_IDX_CNT_EN      5'h02
`define DPT_IDX_PRESET_HI   5'h03
`define DPT_IDX_PRESET_LO   5'h04
`define DPT_IDX_LIVE_HI     5'h05
`define DPT_IDX_LIVE_LO     5'h06
`define DPT_IDX_ERROR       5'h07
`define DPT_CH2_BASE        5'h08
`define DPT_IDX_CTRL        5'h10
`define DPT_IDX_STATUS      5'h11
`define DPT_CTRL_START1_BIT 0
`define DPT_CTRL_START2_BIT 1
`define DPT_FLAG_CH1_BASE   0
`define DPT_FLAG_CH2_BASE   10
`define DPT_RESET_WORD      16'h0000
`define DPT_ERR_NONE        16'h0000
`define DPT_ERR_MODE        16'h0001
`define DPT_ERR_FREQ        16'h0002
`define DPT_ERR_CNT_EN      16'h0003
`define DPT_ERR_PRESET      16'h0004
`define DPT_ERR_CH2_COUNT   16'h0005
`define DPT_PRESET_MAX      32'h05F5_E100
`define DPT_CLK_HZ          40000000
`define DPT_SCAN_US         1000
`define DPT_CLK_MHZ         40

`endif

//--- hdl/dpt_pkg.sv
// Types shared by the pulse train block
// Assumes dpt_regs.svh is on the include path
package dpt_pkg;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] freq;
        logic [15:0] cnt_en;
        logic [15:0] preset_hi;
        logic [15:0] preset_lo;
    } dpt_cfg_t;

    typedef struct packed {
        logic overcount;
        logic done;
        logic running;
    } dpt_flags_t;

    typedef enum logic {
        DPT_IDLE,
        DPT_RUN
    } dpt_state_t;
endpackage

//--- hdl/dpt_top.sv
// Two-channel 50% duty pulse train generator with an AHB-Lite register slave
// Assumes one 40 MHz clock, single-word AHB-Lite transfers, starts set by software
`include "dpt_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module dpt_channel #(
    parameter bit COUNTING = 1'b1
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Control
    input  wire logic              start,
    input  wire logic              scan_tick,
    input  wire dpt_pkg::dpt_cfg_t cfg,
    // Results
    output logic                   pulse_out,
    output dpt_pkg::dpt_flags_t    flags,
    output logic [31:0]            live_count,
    output logic [15:0]            err_code
);
    import dpt_pkg::*;
    localparam logic [24:0] HALF_SCALE = 25'(`DPT_CLK_HZ / 2);
    dpt_state_t  state_q;
    logic        start_q;
    logic        out_q;
    logic [24:0] acc_q;
    logic [14:0] cur_f_q;
    logic [14:0] pend_f_q;
    logic [31:0] count_q;
    logic [31:0] preset_q;
    logic        cnt_on_q;
    logic [31:0] live_q;
    logic [15:0] err_q;
    dpt_flags_t  flags_q;
    logic        start_rise;
    logic [15:0] chk;
    logic [14:0] cfg_f;
    logic        f_ok;
    logic [25:0] sum;
    logic        toggle;
    logic [31:0] preset_in;

    function automatic logic [14:0] freq_hz(input logic [15:0] m, input logic [15:0] f);
        case (m)
            16'h0000: freq_hz = 15'(f * 16'h000A);
            16'h0001: freq_hz = 15'(f * 16'h0064);
            16'h0002: freq_hz = 15'(f * 16'h03E8);
            default:  freq_hz = 15'(f);
        endcase
    endfunction

    function automatic logic freq_valid(input logic [15:0] m, input logic [15:0] f);
        case (m)
            16'h0000, 16'h0001: freq_valid = (f >= 16'h0001) && (f <= 16'h0064);
            16'h0002:           freq_valid = (f >= 16'h0001) && (f <= 16'h0014);
            16'h0003:           freq_valid = (f >= 16'h000A) && (f <= 16'h4E20);
            default:            freq_valid = 1'b0;
        endcase
    endfunction

    assign preset_in  = {cfg.preset_hi, cfg.preset_lo};
    assign start_rise = start && !start_q;
    assign cfg_f      = freq_hz(cfg.mode, cfg.freq);
    assign f_ok       = freq_valid(cfg.mode, cfg.freq);

    // Operand check on start, first failing check wins: mode, freq, cnt_en, channel 2 count, preset
    always_comb begin
        if (cfg.mode > 16'h0003) begin
            chk = `DPT_ERR_MODE;
        end else if (!f_ok) begin
            chk = `DPT_ERR_FREQ;
        end else if (cfg.cnt_en > 16'h0001) begin
            chk = `DPT_ERR_CNT_EN;
        end else if (cfg.cnt_en == 16'h0001 && !COUNTING) begin
            chk = `DPT_ERR_CH2_COUNT;
        end else if (cfg.cnt_en == 16'h0001
                     && (preset_in == 32'h0000_0000 || preset_in > `DPT_PRESET_MAX)) begin
            chk = `DPT_ERR_PRESET;
        end else begin
            chk = `DPT_ERR_NONE;
        end
    end

    // Phase accumulator: exact average rate without a divider
    assign sum    = {1'b0, acc_q} + {11'h000, cur_f_q};
    assign toggle = (sum >= {1'b0, HALF_SCALE});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= 1'b0;
            err_q   <= `DPT_ERR_NONE;
        end else begin
            start_q <= start;
            if (start_rise) begin
                err_q <= chk;
            end
        end
    end

    // Sampled each scan tick; a bad value keeps the last good rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_f_q <= 15'h0001;
        end else if (start_rise || (scan_tick && f_ok)) begin
            pend_f_q <= cfg_f;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= DPT_IDLE;
            out_q    <= 1'b0;
            acc_q    <= 25'h000_0000;
            cur_f_q  <= 15'h0001;
            count_q  <= 32'h0000_0000;
            preset_q <= 32'h0000_0000;
            cnt_on_q <= 1'b0;
            flags_q  <= '0;
        end else begin
            case (state_q)
                DPT_IDLE: begin
                    if (start_rise && chk == `DPT_ERR_NONE) begin
                        state_q         <= DPT_RUN;
                        flags_q         <= 3'b001;
                        acc_q           <= 25'h000_0000;
                        cur_f_q         <= cfg_f;
                        count_q         <= 32'h0000_0000;
                        preset_q        <= preset_in;
                        cnt_on_q        <= COUNTING && cfg.cnt_en == 16'h0001;
                    end
                end
                DPT_RUN: begin
                    if (!start) begin
                        state_q         <= DPT_IDLE;
                        out_q           <= 1'b0;
                        flags_q.running <= 1'b0;
                        flags_q.done    <= 1'b1;
                    end else if (toggle) begin
                        acc_q <= 25'(sum - {1'b0, HALF_SCALE});
                        out_q <= !out_q;
                        if (!out_q) begin
                            count_q <= count_q + 32'h0000_0001;
                            cur_f_q <= pend_f_q;
                        end else if (cnt_on_q && count_q == preset_q) begin
                            state_q         <= DPT_IDLE;
                            flags_q.running <= 1'b0;
                            flags_q.done    <= 1'b1;
                        end
                    end else begin
                        acc_q <= 25'(sum);
                    end
                    if (cnt_on_q && count_q > preset_q) begin
                        flags_q.overcount <= 1'b1;
                    end
                end
                default: begin
                    state_q <= DPT_IDLE;
                    out_q   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_q <= 32'h0000_0000;
        end else if (COUNTING && scan_tick) begin
            live_q <= count_q;
        end
    end

    assign pulse_out  = out_q;
    assign flags      = flags_q;
    assign live_count = live_q;
    assign err_code   = err_q;

    AST_IDLE_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == DPT_IDLE |-> !out_q)
        else $error("output high while idle");
    AST_STOP_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == DPT_RUN && !start |=> state_q == DPT_IDLE && !out_q && flags_q.done)
        else $error("channel did not stop at once");
    AST_KEEP_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == DPT_RUN && start && !cnt_on_q |=> state_q == DPT_RUN)
        else $error("uncounted channel stopped while started");
    AST_START_OK: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == DPT_IDLE && start_rise && chk == `DPT_ERR_NONE
        |=> flags_q == 3'b001 && err_q == `DPT_ERR_NONE)
        else $error("flags wrong after good start");
    AST_BAD_START: assert property (@(posedge hclk) disable iff (!hresetn)
        start_rise && chk != `DPT_ERR_NONE |=> state_q == DPT_IDLE && err_q == $past(chk))
        else $error("bad operands not refused");
    AST_PRESET_END: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == DPT_RUN && start && toggle && out_q && cnt_on_q && count_q == preset_q
        |=> !flags_q.running && flags_q.done && !out_q)
        else $error("preset end missed");
    AST_LIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        COUNTING && scan_tick |=> live_q == $past(count_q))
        else $error("live count not refreshed");
    AST_NO_OVER_CH2: assert property (@(posedge hclk) disable iff (!hresetn)
        !COUNTING |-> !flags_q.overcount && !cnt_on_q)
        else $error("channel 2 counting");
    AST_RUN_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_q.running |-> state_q == DPT_RUN)
        else $error("running flag without pulses");
endmodule

////////////////////////////////////////////////////////////////////////////////
module dpt_top #(
    parameter int unsigned SCAN_CYCLES = `DPT_SCAN_US * `DPT_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pulse outputs
    output logic             pulse_out_ch1,
    output logic             pulse_out_ch2
);
    import dpt_pkg::*;

    dpt_cfg_t    cfg_q [2];
    logic [1:0]  start_q;
    logic        wr_pend_q;
    logic [4:0]  wr_idx_q;
    logic [31:0] scan_cnt_q;
    logic        scan_tick_q;
    logic        take;
    logic [4:0]  a_idx;
    logic        ch2_hit;
    logic [2:0]  a_off;
    logic [15:0] wdat;
    dpt_flags_t  flags [2];
    logic [31:0] live [2];
    logic [15:0] err [2];
    logic [31:0] rd_mux;

    assign take  = hsel && hready && htrans[1];
    assign a_idx = haddr[6:2];
    assign wdat  = hwdata[15:0];

    // Scan tick paces frequency sampling and live-count refresh
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_cnt_q  <= 32'h0000_0000;
            scan_tick_q <= 1'b0;
        end else if (scan_cnt_q == SCAN_CYCLES - 1) begin
            scan_cnt_q  <= 32'h0000_0000;
            scan_tick_q <= 1'b1;
        end else begin
            scan_cnt_q  <= scan_cnt_q + 32'h0000_0001;
            scan_tick_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 5'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_idx_q  <= a_idx;
        end
    end

    // Data-phase writes; words 5..7 of each block have no storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
            start_q  <= 2'b00;
        end else if (wr_pend_q) begin
            if (wr_idx_q == `DPT_IDX_CTRL) begin
                start_q <= {wdat[`DPT_CTRL_START2_BIT], wdat[`DPT_CTRL_START1_BIT]};
            end else if (wr_idx_q < 5'h10) begin
                case (wr_idx_q[2:0])
                    3'h0: cfg_q[wr_idx_q[3]].mode      <= wdat;
                    3'h1: cfg_q[wr_idx_q[3]].freq      <= wdat;
                    3'h2: cfg_q[wr_idx_q[3]].cnt_en    <= wdat;
                    3'h3: cfg_q[wr_idx_q[3]].preset_hi <= wdat;
                    3'h4: cfg_q[wr_idx_q[3]].preset_lo <= wdat;
                    default: ;
                endcase
            end
        end
    end

    // Read mux over the two blocks, control and status
    assign ch2_hit = a_idx[3];
    assign a_off   = a_idx[2:0];
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a_idx == `DPT_IDX_CTRL) begin
            rd_mux = {30'h0000_0000, start_q};
        end else if (a_idx == `DPT_IDX_STATUS) begin
            rd_mux[`DPT_FLAG_CH1_BASE +: 3] = flags[0];
            rd_mux[`DPT_FLAG_CH2_BASE +: 3] = flags[1];
        end else if (a_idx < 5'h10) begin
            case (a_off)
                3'h0: rd_mux[15:0] = cfg_q[ch2_hit].mode;
                3'h1: rd_mux[15:0] = cfg_q[ch2_hit].freq;
                3'h2: rd_mux[15:0] = cfg_q[ch2_hit].cnt_en;
                3'h3: rd_mux[15:0] = cfg_q[ch2_hit].preset_hi;
                3'h4: rd_mux[15:0] = cfg_q[ch2_hit].preset_lo;
                3'h5: rd_mux[15:0] = live[ch2_hit][31:16];
                3'h6: rd_mux[15:0] = live[ch2_hit][15:0];
                default: rd_mux[15:0] = err[ch2_hit];
            endcase
        end
    end

    // Read data registered at the address phase; a write landing now is forwarded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            if (wr_pend_q && wr_idx_q == a_idx
                && (a_idx == `DPT_IDX_CTRL || (a_idx < 5'h10 && a_off < 3'h5))) begin
                hrdata <= (a_idx == `DPT_IDX_CTRL)
                          ? {30'h0000_0000, wdat[1:0]} : {16'h0000, wdat};
            end else begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    dpt_channel #(.COUNTING(1'b1)) u_ch1 (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .start      (start_q[0]),
        .scan_tick  (scan_tick_q),
        .cfg        (cfg_q[0]),
        .pulse_out  (pulse_out_ch1),
        .flags      (flags[0]),
        .live_count (live[0]),
        .err_code   (err[0])
    );
    dpt_channel #(.COUNTING(1'b0)) u_ch2 (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .start      (start_q[1]),
        .scan_tick  (scan_tick_q),
        .cfg        (cfg_q[1]),
        .pulse_out  (pulse_out_ch2),
        .flags      (flags[1]),
        .live_count (live[1]),
        .err_code   (err[1])
    );
endmodule

//--- tb/dpt_pulse_load.sv
// Pulse-input load on one pulse output: counts rising edges, times high and low spans
// Assumes a synchronous pulse level from the block, sampled on the same clock
module dpt_pulse_load (
    // Clock
    input  wire logic        clk,
    // Pulse input
    input  wire logic        pulse,
    // Measurements
    output logic [31:0]      n_rise,
    output logic [31:0]      hi_len,
    output logic [31:0]      lo_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        lvl_q;
    logic [31:0] span_q;
    initial begin
        lvl_q  = 1'b0;
        span_q = 32'h0000_0000;
        n_rise = 32'h0000_0000;
        hi_len = 32'h0000_0000;
        lo_len = 32'h0000_0000;
    end
    // Whole cycles per level, so a half-duty train reads equal spans
    always @(posedge clk) begin
        lvl_q  <= pulse;
        span_q <= (pulse !== lvl_q) ? 32'h0000_0001 : span_q + 1;
        if (pulse === 1'b1 && lvl_q === 1'b0) begin
            n_rise <= n_rise + 1;
            lo_len <= span_q;
        end
        if (pulse === 1'b0 && lvl_q === 1'b1) begin
            hi_len <= span_q;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench: register map, frequency table, error codes, counting, channel 2
// Assumes dpt_regs.svh on the include path; scan period shortened to keep runs short
`include "dpt_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, out1, out2;
    logic [31:0] haddr, hwdata, hrdata, n1, h1, l1, n2, h2, l2;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_errors, num_checks;
    assign hready = hreadyout;
    dpt_top #(.SCAN_CYCLES(100)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pulse_out_ch1(out1), .pulse_out_ch2(out2));
    dpt_pulse_load load1 (.clk(hclk), .pulse(out1), .n_rise(n1), .hi_len(h1), .lo_len(l1));
    dpt_pulse_load load2 (.clk(hclk), .pulse(out2), .n_rise(n2), .hi_len(h2), .lo_len(l2));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Phase accumulator may jitter one cycle
    task automatic near(string nm, logic [31:0] seen, int exp);
        chk(nm, (seen >= exp - 1 && seen <= exp + 1) ? exp : seen, exp);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic edge_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 50) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 50) begin
            n_errors++;
        end
    endtask
    task automatic bus(logic w, logic [4:0] i, logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {25'h0, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        edge_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy();
        r = hrdata;
    endtask
    task automatic wr(logic [4:0] i, logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, i, d, v);
    endtask
    task automatic rdc(string nm, logic [4:0] i, logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, i, 32'h0, v);
        chk(nm, v, e);
    endtask
    task automatic cfg(logic [4:0] b, logic [15:0] m, f, ce, logic [31:0] p);
        wr(b + `DPT_IDX_RANGE, m);
        wr(b + `DPT_IDX_FREQ, f);
        wr(b + `DPT_IDX_CNT_EN, ce);
        wr(b + `DPT_IDX_PRESET_HI, p[31:16]);
        wr(b + `DPT_IDX_PRESET_LO, p[15:0]);
    endtask
    function automatic int half(int m, int f);
        int hz;
        hz = (m == 0) ? 10 * f : (m == 1) ? 100 * f : (m == 2) ? 1000 * f : f;
        return `DPT_CLK_HZ / 2 / hz;
    endfunction
    task automatic rises(int ch, int n);
        logic [31:0] t;
        int k;
        t = (ch == 1 ? n1 : n2) + n;
        k = 0;
        while ((ch == 1 ? n1 : n2) !== t && k < 30000) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 30000) begin
            n_errors++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            rdc("reset word", 5'(i), 32'h0000_0000);
        end
        rdc("reset status", `DPT_IDX_STATUS, 32'h0000_0000);
        chk("idle outputs", {out2, out1}, 2'b00);
        chk("bus ready and okay", {hreadyout, hresp}, 2'b10);
    endtask
    task automatic t_access();
        for (int i = 0; i < 16; i++) begin
            wr(5'(i), 32'h0000_A5A0 + i);
        end
        for (int i = 0; i < 16; i++) begin
            rdc("word access", 5'(i), (i % 8 < 5) ? 32'h0000_A5A0 + i : 0);
        end
        wr(`DPT_IDX_STATUS, 32'h0000_FFFF);
        rdc("status write", `DPT_IDX_STATUS, 32'h0000_0000);
        wr(5'h1F, 32'hFFFF_FFFF);
        rdc("unmapped", 5'h1F, 32'h0000_0000);
        cfg(5'h00, 0, 0, 0, 0);
        cfg(`DPT_CH2_BASE, 0, 0, 0, 0);
    endtask
    task automatic t_stop(int ch);
        logic [31:0] v, s;
        wr(`DPT_IDX_CTRL, 0);
        repeat (4) @(posedge hclk);
        s = (ch == 1) ? n1 : n2;
        chk("stopped pin", ch == 1 ? out1 : out2, 0);
        bus(1'b0, `DPT_IDX_STATUS, 0, v);
        chk("stop flags", ch == 1 ? v[2:0] : v[12:10], 3'b010);
        repeat (3000) @(posedge hclk);
        chk("no pulses after stop", (ch == 1) ? n1 : n2, s);
    endtask
    task automatic t_freq(int m, int f);
        logic [31:0] v;
        cfg(5'h00, m, f, 0, 0);
        wr(`DPT_IDX_CTRL, 1);
        rises(1, 3);
        near("high span", h1, half(m, f));
        near("low span", l1, half(m, f));
        rdc("error ok", `DPT_IDX_ERROR, 0);
        bus(1'b0, `DPT_IDX_STATUS, 0, v);
        chk("running", v[2:0], 3'b001);
    endtask
    task automatic err_case(int ch, logic [15:0] m, f, ce, logic [31:0] p, logic [15:0] c);
        logic [31:0] v;
        logic [4:0]  b;
        b = (ch == 1) ? 5'h00 : `DPT_CH2_BASE;
        cfg(b, m, f, ce, p);
        wr(`DPT_IDX_CTRL, ch);
        repeat (4) @(posedge hclk);
        rdc("error code", b + `DPT_IDX_ERROR, c);
        bus(1'b0, `DPT_IDX_STATUS, 0, v);
        chk("run on good operands", ch == 1 ? v[0] : v[10], c == 0);
        wr(`DPT_IDX_CTRL, 0);
    endtask
    task automatic t_count();
        logic [31:0] v, s;
        int k;
        cfg(5'h00, 3, 20000, 1, 3);
        s = n1;
        wr(`DPT_IDX_CTRL, 1);
        rises(1, 1);
        k = 0;
        v = 1;
        while (v[0] !== 1'b0 && k < 100) begin
            repeat (100) @(posedge hclk);
            bus(1'b0, `DPT_IDX_STATUS, 0, v);
            k++;
        end
        repeat (3000) @(posedge hclk);
        chk("preset pulses", n1 - s, 3);
        chk("pin after count", out1, 0);
        chk("count flags", v[2:0], 3'b010);
        rdc("live high", `DPT_IDX_LIVE_HI, 0);
        rdc("live low", `DPT_IDX_LIVE_LO, 3);
        wr(`DPT_IDX_CTRL, 0);
        wr(`DPT_IDX_CTRL, 1);
        rises(1, 1);
        bus(1'b0, `DPT_IDX_STATUS, 0, v);
        chk("restart flags", v[2:0], 3'b001);
        wr(`DPT_IDX_CTRL, 0);
    endtask
    task automatic t_both();
        logic [31:0] s;
        cfg(5'h00, 3, 10000, 0, 0);
        cfg(`DPT_CH2_BASE, 2, 20, 0, 0);
        wr(`DPT_IDX_CTRL, 3);
        rises(2, 1);
        s = n1;
        rises(2, 8);
        near("ch2 high span", h2, 1000);
        near("ch2 low span", l2, 1000);
        near("ch1 beside ch2", h1, 2000);
        chk("ch1 pulses meanwhile", n1 - s, 4);
        rdc("ch2 live", `DPT_CH2_BASE + `DPT_IDX_LIVE_LO, 0);
        wr(`DPT_IDX_CTRL, 1);
        repeat (4) @(posedge hclk);
        chk("ch2 stopped", out2, 0);
        t_stop(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        repeat (95000) @(posedge hclk);
        n_errors++;
        close_out();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_access();
        t_freq(1, 100);
        wr(`DPT_IDX_FREQ, 50);
        rises(1, 3);
        near("retuned span", h1, half(1, 50));
        t_stop(1);
        t_freq(2, 20);
        t_stop(1);
        t_freq(3, 20000);
        t_stop(1);
        err_case(1, 4, 50, 0, 0, 1);
        err_case(1, 0, 100, 0, 0, 0);
        err_case(1, 0, 101, 0, 0, 2);
        err_case(1, 1, 0, 0, 0, 2);
        err_case(1, 2, 21, 0, 0, 2);
        err_case(1, 2, 1, 0, 0, 0);
        err_case(1, 3, 9, 0, 0, 2);
        err_case(1, 3, 20001, 0, 0, 2);
        err_case(1, 3, 10, 0, 0, 0);
        err_case(1, 1, 50, 2, 0, 3);
        err_case(1, 1, 50, 1, 0, 4);
        err_case(1, 1, 50, 1, 32'h05F5_E101, 4);
        err_case(1, 1, 50, 1, 32'h05F5_E100, 0);
        err_case(2, 1, 50, 1, 0, 5);
        err_case(2, 2, 20, 0, 0, 0);
        t_count();
        t_both();
        close_out();
    end
endmodule
